// ===== verilog/timer_params.svh
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH
// register byte offsets
`define CFG_ADDR        8'h00
`define CTRL_ADDR       8'h04
`define COUNT_ADDR      8'h08
`define STATE_ADDR      8'h0C
`define INSEL_ADDR      8'h10
`define FLAG_ADDR       8'h14
`define IRQEN_ADDR      8'h18
`define CAPMODE_ADDR    8'h1C
`define DMAEN_ADDR      8'h20
`define OUTTOG_BASE     8'h40
`define MATCH_BASE      8'h80
`define CAPEV_BASE      8'hA0
`define EVCFG_BASE      8'hC0
`define EVSTATE_BASE    8'hE0
// config fields
`define CFG_UNIFY       0
`define CFG_CLKSEL_L    1
`define CFG_CKIN_LSB    3
`define CFG_BIDIR_L     6
`define CFG_AUTOLIM_L   8
`define CFG_ADCSEL_LSB  10
// control fields, high counter bits sit at +2 (halt/stop) and +1 (dir)
`define CTRL_HALT_L     0
`define CTRL_STOP_L     1
`define CTRL_DIR_L      4
// reset values
`define CFG_RESET       32'h00000001
`define CTRL_RESET      6'h05
`endif

// ===== verilog/timer_pkg.sv
package timer_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        we;
        logic        re;
    } bus_req_s;

    typedef struct packed {
        logic adc_thr;
        logic cmp_out;
        logic core_event_out;
        logic cpu_halt_indicator;
    } int_src_s;

    typedef enum logic [1:0] {IO_LOW, IO_RISE, IO_FALL, IO_HIGH} io_cond_e;
    typedef enum logic [1:0] {COMB_OR, COMB_MATCH, COMB_IO, COMB_AND} ev_comb_e;
    typedef enum logic [1:0] {DIR_ANY, DIR_UP, DIR_DOWN, DIR_ANY_ALT} dir_qual_e;

    typedef struct packed {
        logic [6:0] rsvd_hi;
        logic [2:0] next_state;
        logic       load_state;
        logic       reverse;
        logic       stop;
        logic       start;
        logic       halt;
        logic       limit;
        logic       hold;
        dir_qual_e  dir_qual;
        ev_comb_e   combine;
        logic [2:0] io_idx;
        logic       io_is_out;
        io_cond_e   io_cond;
        logic       hsel;
        logic       rsvd_lo;
        logic [2:0] match_sel;
    } ev_cfg_s;
endpackage

// ===== verilog/state_config_timer_pwm.sv
// How it works
// - one 32-bit or two 16-bit counters
// - eight registers, each match or capture
// - five inputs, fifth tied to clock source
// - same eight sources on every input selector
// - six outputs toward the switch matrix
// - count on system clock or input edge
// - count up only or up-down
// - match drives irq, counter actions, toggles
// - events copy counter into capture register
// - toggled outputs give PWM, shared period
// - events from match, io, or both
// - events limit, halt, start, stop, reverse
// - events move state, toggle, irq, dma
// - match 0 as automatic limit
// - events qualified by count direction
// - match may stay pending until event
// - eight states gate the enabled events
// - state survives wraps, changes by events
// - selected output triggers the converter
`timescale 1ns/1ns
`include "timer_params.svh"

module state_config_timer_pwm #(
    parameter int NUM_EV    = 8,
    parameter int NUM_MATCH = 8,
    parameter int NUM_OUT   = 6
) (
    input  wire logic                clock_in,
    input  wire logic                rst_n_in,
    input  wire logic                ce_in,
    input  wire timer_pkg::bus_req_s bus_in,
    output logic [31:0]              rdata_out,
    input  wire logic [3:0]          pin_in,
    input  wire logic                clk_src_in,
    input  wire timer_pkg::int_src_s int_src_in,
    output logic [NUM_OUT-1:0]       out_out,
    output logic                     adc_trig_out,
    output logic                     irq_out,
    output logic                     dma_req_out
);
    import timer_pkg::*;
    logic [31:0]          cfg_q, cfg_d, cnt_q, cnt_d, rdata_q, rdata_d;
    logic [5:0]           ctrl_q, ctrl_d;
    logic [2:0]           state_q, state_d;
    logic [11:0]          insel_q, insel_d;
    logic [NUM_EV-1:0]    flag_q, flag_d, irqen_q, irqen_d, dmaen_q, dmaen_d, pend_q, pend_d;
    logic [NUM_MATCH-1:0] capmode_q, capmode_d;
    logic [NUM_EV-1:0]    outtog_q [NUM_OUT];
    logic [NUM_EV-1:0]    outtog_d [NUM_OUT];
    logic [31:0]          match_q [NUM_MATCH];
    logic [31:0]          match_d [NUM_MATCH];
    logic [NUM_EV-1:0]    capev_q [NUM_MATCH];
    logic [NUM_EV-1:0]    capev_d [NUM_MATCH];
    ev_cfg_s              evcfg_q [NUM_EV];
    ev_cfg_s              evcfg_d [NUM_EV];
    logic [7:0]           evst_q [NUM_EV];
    logic [7:0]           evst_d [NUM_EV];
    logic [4:0]           in_q, in_now;
    logic [NUM_OUT-1:0]   out_q, out_d, outp_q;
    logic                 irq_q, irq_d, dma_q, dma_d, adc_q, adc_d;
    logic [7:0]           in_pad, inp_pad, out_pad, outp_pad;
    logic [NUM_MATCH-1:0] hit [2];
    logic [NUM_EV-1:0]    fire, raw_m;
    logic [1:0]           tick, run, auto_hit;
    logic [1:0]           act_lim, act_halt, act_start, act_stop, act_rev;
    logic                 unify, ev_ctl_any, load_any;
    logic                 cnt_wr, ctrl_wr, state_wr, flag_wr;
    logic [2:0]           idx, ckin, adc_sel;
    function automatic logic [31:0] half_val(input logic [31:0] v, input logic u, input logic h);
        return u ? v : (h ? {16'h0000, v[31:16]} : {16'h0000, v[15:0]});
    endfunction
    function automatic logic in_blk(input logic [7:0] a, input logic [7:0] base);
        return a[7:5] == base[7:5];
    endfunction
    function automatic logic src_pick(input logic [2:0] sel, input logic [3:0] pins, input int_src_s s);
        logic r;
        r = pins[sel[1:0]];
        if (sel[2]) begin
            case (sel[1:0])
                2'h0: r = s.adc_thr;
                2'h1: r = s.cmp_out;
                2'h2: r = s.core_event_out;
                default: r = s.cpu_halt_indicator;
            endcase
        end
        return r;
    endfunction
    assign idx      = bus_in.addr[4:2];
    assign cnt_wr   = bus_in.we && (bus_in.addr == `COUNT_ADDR);
    assign ctrl_wr  = bus_in.we && (bus_in.addr == `CTRL_ADDR);
    assign state_wr = bus_in.we && (bus_in.addr == `STATE_ADDR);
    assign flag_wr  = bus_in.we && (bus_in.addr == `FLAG_ADDR);
    assign unify    = cfg_q[`CFG_UNIFY];
    assign ckin     = cfg_q[`CFG_CKIN_LSB +: 3];
    assign adc_sel  = cfg_q[`CFG_ADCSEL_LSB +: 3];
    ////////////////////////////////////////////////////////////////////////////
    // input selection and event evaluation
    always_comb begin
        ev_cfg_s c;
        logic    h, m, cur, prv, io, cmb, dok;
        c   = '0;
        {h, m, cur, prv, io, cmb, dok} = 7'h00;
        for (int i = 0; i < 4; i++) begin
            in_now[i] = src_pick(insel_q[3*i +: 3], pin_in, int_src_in);
        end
        in_now[4] = clk_src_in;
        in_pad    = 8'(in_now);
        inp_pad   = 8'(in_q);
        out_pad   = 8'(out_q);
        outp_pad  = 8'(outp_q);
        for (int k = 0; k < 2; k++) begin
            tick[k] = cfg_q[`CFG_CLKSEL_L + k] ? (in_pad[ckin] & ~inp_pad[ckin]) : 1'b1;
            run[k]  = tick[k] & ~ctrl_q[`CTRL_HALT_L + 2*k] & ~ctrl_q[`CTRL_STOP_L + 2*k];
            for (int n = 0; n < NUM_MATCH; n++) begin
                hit[k][n] = ~capmode_q[n] &&
                            (half_val(cnt_q, unify, 1'(k)) == half_val(match_q[n], unify, 1'(k)));
            end
            auto_hit[k] = cfg_q[`CFG_AUTOLIM_L + k] & hit[k][0];
        end
        {act_lim, act_halt, act_start, act_stop, act_rev} = 10'h000;
        load_any  = 1'b0;
        for (int e = 0; e < NUM_EV; e++) begin
            c        = evcfg_q[e];
            h        = c.hsel & ~unify;
            raw_m[e] = hit[h][c.match_sel];
            m        = raw_m[e] | pend_q[e];
            cur      = c.io_is_out ? out_pad[c.io_idx] : in_pad[c.io_idx];
            prv      = c.io_is_out ? outp_pad[c.io_idx] : inp_pad[c.io_idx];
            case (c.io_cond)
                IO_LOW:  io = ~cur;
                IO_RISE: io = cur & ~prv;
                IO_FALL: io = ~cur & prv;
                default: io = cur;
            endcase
            case (c.combine)
                COMB_OR:    cmb = m | io;
                COMB_MATCH: cmb = m;
                COMB_IO:    cmb = io;
                default:    cmb = m & io;
            endcase
            case (c.dir_qual)
                DIR_UP:   dok = ~ctrl_q[`CTRL_DIR_L + h];
                DIR_DOWN: dok = ctrl_q[`CTRL_DIR_L + h];
                default:  dok = 1'b1;
            endcase
            fire[e] = cmb & dok & evst_q[e][state_q];
            act_lim[h]   = act_lim[h] | (fire[e] & c.limit);
            act_halt[h]  = act_halt[h] | (fire[e] & c.halt);
            act_start[h] = act_start[h] | (fire[e] & c.start);
            act_stop[h]  = act_stop[h] | (fire[e] & c.stop);
            act_rev[h]   = act_rev[h] | (fire[e] & c.reverse);
            load_any     = load_any | (fire[e] & c.load_state);
        end
        ev_ctl_any = |{act_lim, act_halt, act_start, act_stop, act_rev};
    end
    ////////////////////////////////////////////////////////////////////////////
    // next values: bus writes, counters, state, flags, outputs
    always_comb begin
        logic [31:0] v, mx, nv;
        logic [5:0]  base;
        logic        dn, lim;
        {v, mx, nv} = 96'h0;
        base        = ctrl_q;
        {dn, lim}   = 2'h0;
        cfg_d     = cfg_q;
        insel_d   = insel_q;
        irqen_d   = irqen_q;
        dmaen_d   = dmaen_q;
        capmode_d = capmode_q;
        outtog_d  = outtog_q;
        match_d   = match_q;
        capev_d   = capev_q;
        evcfg_d   = evcfg_q;
        evst_d    = evst_q;
        if (bus_in.we) begin
            if (bus_in.addr == `CFG_ADDR) begin
                cfg_d = bus_in.wdata;
            end else if (bus_in.addr == `INSEL_ADDR) begin
                insel_d = bus_in.wdata[11:0];
            end else if (bus_in.addr == `IRQEN_ADDR) begin
                irqen_d = bus_in.wdata[NUM_EV-1:0];
            end else if (bus_in.addr == `CAPMODE_ADDR) begin
                capmode_d = bus_in.wdata[NUM_MATCH-1:0];
            end else if (bus_in.addr == `DMAEN_ADDR) begin
                dmaen_d = bus_in.wdata[NUM_EV-1:0];
            end else if (in_blk(bus_in.addr, `OUTTOG_BASE) && idx < NUM_OUT) begin
                outtog_d[idx] = bus_in.wdata[NUM_EV-1:0];
            end else if (in_blk(bus_in.addr, `MATCH_BASE)) begin
                match_d[idx] = bus_in.wdata;
            end else if (in_blk(bus_in.addr, `CAPEV_BASE)) begin
                capev_d[idx] = bus_in.wdata[NUM_EV-1:0];
            end else if (in_blk(bus_in.addr, `EVCFG_BASE)) begin
                evcfg_d[idx] = ev_cfg_s'(bus_in.wdata);
            end else if (in_blk(bus_in.addr, `EVSTATE_BASE)) begin
                evst_d[idx] = bus_in.wdata[7:0];
            end
        end
        if (ctrl_wr) begin
            base[3:0] = bus_in.wdata[3:0];
        end
        ctrl_d = base;
        cnt_d  = cnt_q;
        for (int k = 0; k < 2; k++) begin
            if (k == 0 || !unify) begin
                v   = half_val(cnt_q, unify, 1'(k));
                mx  = unify ? 32'hFFFFFFFF : 32'h0000FFFF;
                dn  = ctrl_q[`CTRL_DIR_L + k];
                lim = act_lim[k] | auto_hit[k];
                nv  = v;
                if (run[k]) begin
                    if (!dn) begin
                        if (lim || v == mx) begin
                            if (cfg_q[`CFG_BIDIR_L + k]) begin
                                dn = 1'b1;
                                nv = v - 32'h1;
                            end else begin
                                nv = 32'h0;
                            end
                        end else begin
                            nv = v + 32'h1;
                        end
                    end else if (v == 32'h0) begin
                        dn = 1'b0;
                        nv = 32'h1;
                    end else begin
                        nv = v - 32'h1;
                    end
                end
                nv = nv & mx;
                ctrl_d[`CTRL_DIR_L + k]  = dn ^ act_rev[k];
                ctrl_d[`CTRL_HALT_L + 2*k] = base[`CTRL_HALT_L + 2*k] | act_halt[k];
                ctrl_d[`CTRL_STOP_L + 2*k] = (base[`CTRL_STOP_L + 2*k] & ~act_start[k]) | act_stop[k];
                if (unify) begin
                    cnt_d = nv;
                end else if (k == 1) begin
                    cnt_d[31:16] = nv[15:0];
                end else begin
                    cnt_d[15:0] = nv[15:0];
                end
            end
        end
        if (cnt_wr) begin
            cnt_d = bus_in.wdata;
        end
        state_d = state_q;
        for (int e = NUM_EV - 1; e >= 0; e--) begin
            if (fire[e] && evcfg_q[e].load_state) begin
                state_d = evcfg_q[e].next_state;
            end
        end
        if (state_wr) begin
            state_d = bus_in.wdata[2:0];
        end
        for (int e = 0; e < NUM_EV; e++) begin
            pend_d[e] = evcfg_q[e].hold & (pend_q[e] | raw_m[e]) & ~fire[e];
        end
        for (int n = 0; n < NUM_MATCH; n++) begin
            if (capmode_q[n] && |(fire & capev_q[n])) begin
                match_d[n] = cnt_q;
            end
        end
        for (int o = 0; o < NUM_OUT; o++) begin
            out_d[o] = out_q[o] ^ (|(fire & outtog_q[o]));
        end
        flag_d = (flag_q & ~(flag_wr ? bus_in.wdata[NUM_EV-1:0] : {NUM_EV{1'b0}})) | fire;
        irq_d  = |(flag_d & irqen_d);
        dma_d  = |(fire & dmaen_q);
        adc_d  = (adc_sel < NUM_OUT) ? out_d[adc_sel] : 1'b0;
        rdata_d = 32'h0;
        if (bus_in.re) begin
            if (bus_in.addr == `CFG_ADDR) begin
                rdata_d = cfg_q;
            end else if (bus_in.addr == `CTRL_ADDR) begin
                rdata_d = 32'(ctrl_q);
            end else if (bus_in.addr == `COUNT_ADDR) begin
                rdata_d = cnt_q;
            end else if (bus_in.addr == `STATE_ADDR) begin
                rdata_d = 32'(state_q);
            end else if (bus_in.addr == `INSEL_ADDR) begin
                rdata_d = 32'(insel_q);
            end else if (bus_in.addr == `FLAG_ADDR) begin
                rdata_d = 32'(flag_q);
            end else if (bus_in.addr == `IRQEN_ADDR) begin
                rdata_d = 32'(irqen_q);
            end else if (bus_in.addr == `CAPMODE_ADDR) begin
                rdata_d = 32'(capmode_q);
            end else if (bus_in.addr == `DMAEN_ADDR) begin
                rdata_d = 32'(dmaen_q);
            end else if (in_blk(bus_in.addr, `OUTTOG_BASE) && idx < NUM_OUT) begin
                rdata_d = 32'(outtog_q[idx]);
            end else if (in_blk(bus_in.addr, `MATCH_BASE)) begin
                rdata_d = match_q[idx];
            end else if (in_blk(bus_in.addr, `CAPEV_BASE)) begin
                rdata_d = 32'(capev_q[idx]);
            end else if (in_blk(bus_in.addr, `EVCFG_BASE)) begin
                rdata_d = 32'(evcfg_q[idx]);
            end else if (in_blk(bus_in.addr, `EVSTATE_BASE)) begin
                rdata_d = 32'(evst_q[idx]);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_q     <= `CFG_RESET;
            ctrl_q    <= `CTRL_RESET;
            cnt_q     <= 32'h0;
            state_q   <= 3'h0;
            insel_q   <= 12'h000;
            flag_q    <= '0;
            irqen_q   <= '0;
            dmaen_q   <= '0;
            pend_q    <= '0;
            capmode_q <= '0;
            in_q      <= 5'h00;
            out_q     <= '0;
            outp_q    <= '0;
            irq_q     <= 1'b0;
            dma_q     <= 1'b0;
            adc_q     <= 1'b0;
            rdata_q   <= 32'h0;
            outtog_q  <= '{default: '0};
            match_q   <= '{default: 32'h0};
            capev_q   <= '{default: '0};
            evcfg_q   <= '{default: '0};
            evst_q    <= '{default: 8'h00};
        end else if (ce_in) begin
            cfg_q     <= cfg_d;
            ctrl_q    <= ctrl_d;
            cnt_q     <= cnt_d;
            state_q   <= state_d;
            insel_q   <= insel_d;
            flag_q    <= flag_d;
            irqen_q   <= irqen_d;
            dmaen_q   <= dmaen_d;
            pend_q    <= pend_d;
            capmode_q <= capmode_d;
            in_q      <= in_now;
            out_q     <= out_d;
            outp_q    <= out_q;
            irq_q     <= irq_d;
            dma_q     <= dma_d;
            adc_q     <= adc_d;
            rdata_q   <= rdata_d;
            outtog_q  <= outtog_d;
            match_q   <= match_d;
            capev_q   <= capev_d;
            evcfg_q   <= evcfg_d;
            evst_q    <= evst_d;
        end
    end
    assign rdata_out    = rdata_q;
    assign out_out      = out_q;
    assign adc_trig_out = adc_q;
    assign irq_out      = irq_q;
    assign dma_req_out  = dma_q;
    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);
    a_flag_set_wins: assert property (ce_in && fire[0] |=> flag_q[0])
        else $error("event flag lost");
    a_irq_masked_or: assert property (irq_out == |(flag_q & irqen_q))
        else $error("irq differs from masked flags");
    a_dma_on_event: assert property (ce_in && |(fire & dmaen_q) |=> dma_req_out)
        else $error("dma request missing");
    a_out_toggles: assert property (ce_in && |(fire & outtog_q[0]) |=> out_out[0] != $past(out_out[0]))
        else $error("output did not toggle");
    a_state_keeps: assert property (ce_in && !load_any && !state_wr |=> $stable(state_q))
        else $error("state moved without event");
    a_state_loads: assert property (ce_in && fire[0] && evcfg_q[0].load_state && !state_wr
                                    |=> state_q == $past(evcfg_q[0].next_state))
        else $error("state not loaded");
    a_count_up: assert property (ce_in && unify && run[0] && !ctrl_q[`CTRL_DIR_L] && !auto_hit[0] &&
                                 !ev_ctl_any && !cnt_wr && cnt_q != 32'hFFFFFFFF
                                 |=> cnt_q == $past(cnt_q) + 32'h1)
        else $error("counter did not step up");
    a_auto_limit: assert property (ce_in && unify && run[0] && !ctrl_q[`CTRL_DIR_L] && auto_hit[0] &&
                                   !cfg_q[`CFG_BIDIR_L] && !ev_ctl_any && !cnt_wr |=> cnt_q == 32'h0)
        else $error("limit did not wrap");
    a_halt_freezes: assert property (ce_in && unify && ctrl_q[`CTRL_HALT_L] && !cnt_wr |=> $stable(cnt_q))
        else $error("halted counter moved");
    a_split_halves: assert property (ce_in && !unify && ctrl_q[`CTRL_HALT_L] && !cnt_wr
                                     |=> cnt_q[15:0] == $past(cnt_q[15:0]))
        else $error("low half moved while halted");
    a_capture_load: assert property (ce_in && capmode_q[1] && |(fire & capev_q[1])
                                     |=> match_q[1] == $past(cnt_q))
        else $error("capture missed");
    c_event_fires: cover property (ce_in && |fire);
    c_state_change: cover property (ce_in && load_any);
    c_limit_wrap: cover property (ce_in && run[0] && auto_hit[0]);
    c_dma_request: cover property (dma_req_out);
endmodule // state_config_timer_pwm

// ===== tb/far_side_model.sv
`timescale 1ns/1ns
module far_side_model
    import timer_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    input  wire logic [7:0] want_in,
    output logic [3:0]      pin_out,
    output timer_pkg::int_src_s src_out,
    output logic            clk_src_out
);
    logic [7:0] lvl_q;
    logic       slot_q;
    // levels move only every second cycle
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lvl_q       <= 8'h00;
            slot_q      <= 1'b0;
            clk_src_out <= 1'b0;
        end else begin
            slot_q <= ~slot_q;
            if (slot_q) begin
                lvl_q       <= want_in;
                clk_src_out <= ~clk_src_out;
            end
        end
    end
    assign pin_out = lvl_q[3:0];
    assign src_out = '{adc_thr: lvl_q[4], cmp_out: lvl_q[5], core_event_out: lvl_q[6],
                       cpu_halt_indicator: lvl_q[7]};
endmodule // far_side_model

// ===== tb/state_config_timer_pwm_tb.sv
`timescale 1ns/1ns
`include "timer_params.svh"
module state_config_timer_pwm_tb;
    import timer_pkg::*;
    logic        clock_in = 1'b0;
    logic        rst_n_in = 1'b0;
    bus_req_s    bus_q    = '0;
    logic [7:0]  want_q   = 8'h00;
    logic [31:0] rdata_out;
    logic [3:0]  pin_w;
    logic        clk_src_w;
    int_src_s    src_w;
    logic [5:0]  out_out;
    logic        adc_trig_out;
    logic        irq_out;
    logic        dma_req_out;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          per, t, lim;
    logic [31:0] rv, mv;
    logic        o_prev;
    always #5 clock_in = ~clock_in;
    far_side_model far_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .want_in(want_q),
                          .pin_out(pin_w), .src_out(src_w), .clk_src_out(clk_src_w));
    state_config_timer_pwm dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .bus_in(bus_q),
        .rdata_out(rdata_out), .pin_in(pin_w), .clk_src_in(clk_src_w), .int_src_in(src_w), .out_out(out_out),
        .adc_trig_out(adc_trig_out), .irq_out(irq_out), .dma_req_out(dma_req_out));
    ////////////////////////////////////////////////////////////////
    function automatic int exp_period(input int l);
        return l + 1;
    endfunction
    task automatic final_report();
        if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        bus_q <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clock_in);
        bus_q <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_in);
        bus_q <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge clock_in);
        bus_q <= '0;
        #1 d = rdata_out;
    endtask
    task automatic wait_dma(output int cyc);
        cyc = 0;
        do begin
            @(posedge clock_in);
            #1 cyc++;
            if (cyc > 300) begin
                n_fail++;
                final_report();
            end
        end while (dma_req_out !== 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h040147bf));
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        rd(`CFG_ADDR, rv);
        check(rv, `CFG_RESET, "cfg reset");
        rd(`CTRL_ADDR, rv);
        check(rv, 32'(`CTRL_RESET), "ctrl reset");
        rd(8'h24, rv);
        check(rv, 32'h0, "unmapped read");
        for (int n = 2; n < 8; n++) begin
            mv = $urandom;
            wr(`MATCH_BASE + 8'(4 * n), mv);
            rd(`MATCH_BASE + 8'(4 * n), rv);
            check(rv, mv, "match readback");
        end
        lim = 10 + $urandom_range(20);
        wr(`MATCH_BASE, 32'(lim));
        wr(`MATCH_BASE + 8'h04, 32'(lim / 2));
        wr(`EVCFG_BASE, 32'h0000_0800);
        wr(`EVCFG_BASE + 8'h04, 32'h00E0_0801);
        wr(`EVSTATE_BASE, 32'hFF);
        wr(`EVSTATE_BASE + 8'h04, 32'h01);
        wr(`OUTTOG_BASE, 32'h1);
        wr(`DMAEN_ADDR, 32'h1);
        wr(`IRQEN_ADDR, 32'h1);
        wr(`CFG_ADDR, 32'h101);
        wr(`CTRL_ADDR, 32'h0);
        wait_dma(t);
        o_prev = out_out[0];
        wait_dma(per);
        check(32'(per), 32'(exp_period(lim)), "period");
        check(32'(out_out), 32'(!o_prev), "toggle");
        check(32'(adc_trig_out), 32'(!o_prev), "adc trigger");
        check(32'(irq_out), 32'h1, "irq on");
        rd(`STATE_ADDR, rv);
        check(rv, 32'h3, "state load");
        wait_dma(t);
        wait_dma(t);
        rd(`STATE_ADDR, rv);
        check(rv, 32'h3, "state kept");
        wr(`CAPMODE_ADDR, 32'h2);
        wr(`CAPEV_BASE + 8'h04, 32'h1);
        wait_dma(t);
        rd(`MATCH_BASE + 8'h04, rv);
        check(rv, 32'(lim), "capture");
        wr(`CTRL_ADDR, 32'h30);
        rd(`CTRL_ADDR, rv);
        check(rv, 32'h0, "dir read-only");
        wr(`IRQEN_ADDR, 32'h0);
        wr(`FLAG_ADDR, 32'hFF);
        repeat (3) @(posedge clock_in);
        #1 check(32'(irq_out), 32'h0, "irq masked");
        wr(`EVCFG_BASE + 8'h08, 32'h0000_1020);
        wr(`EVSTATE_BASE + 8'h08, 32'hFF);
        for (int s = 0; s < 8; s++) begin
            wr(`INSEL_ADDR, 32'(s));
            repeat (6) @(posedge clock_in);
            wr(`FLAG_ADDR, 32'h4);
            rd(`FLAG_ADDR, rv);
            check(32'(rv[2]), 32'h0, "flag cleared");
            want_q[s] <= 1'b1;
            repeat (8) @(posedge clock_in);
            rd(`FLAG_ADDR, rv);
            check(32'(rv[2]), 32'h1, "source rise");
            want_q[s] <= 1'b0;
        end
        // low half halted, high half free in split mode
        wr(`CTRL_ADDR, 32'h1);
        wr(`CFG_ADDR, 32'h0);
        rd(`COUNT_ADDR, rv);
        rd(`COUNT_ADDR, mv);
        check(32'(mv[15:0]), 32'(rv[15:0]), "low half held");
        check(32'(mv[31:16]), 32'(rv[31:16]) + 32'h2, "high half counts");
        final_report();
    end
endmodule // state_config_timer_pwm_tb
